//--- spsc_pkg.sv
package spsc_pkg;

    // Scan controller states in the standard test access port order.
    typedef enum logic [3:0] {
        TAP_RESET,
        TAP_IDLE,
        TAP_SEL_DR,
        TAP_CAP_DR,
        TAP_SHIFT_DR,
        TAP_EXIT1_DR,
        TAP_PAUSE_DR,
        TAP_EXIT2_DR,
        TAP_UPD_DR,
        TAP_SEL_IR,
        TAP_CAP_IR,
        TAP_SHIFT_IR,
        TAP_EXIT1_IR,
        TAP_PAUSE_IR,
        TAP_EXIT2_IR,
        TAP_UPD_IR
    } spsc_tap_t;

    // One bit for each shared pin of the test port.
    typedef struct packed {
        logic tck;
        logic tdi;
        logic tdo;
        logic tms;
    } spsc_pins_t;

    localparam int         SPSC_WORD_W       = 8;
    localparam int         SPSC_FIFO_DEPTH   = 16;
    localparam int         SPSC_IR_W         = 4;
    localparam logic [3:0] SPSC_IR_CAPTURE   = 4'h1;
    localparam logic [3:0] SPSC_IR_RESET     = 4'hF;
    localparam int         SPSC_RESET_CYCLES = 5;
    localparam logic [2:0] SPSC_CNT_ONE      = 3'h1;
    localparam logic [2:0] SPSC_CNT_MAX      = 3'h7;
    localparam spsc_pins_t SPSC_SYNC_RESET   = 4'h1; // Idle pins: mode select pulled high.

endpackage : spsc_pkg

//--- spsc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              do_wr = in_valid && in_ready;
    wire              do_rd = out_valid && out_ready;

    // Full and empty come straight from the fill count, so neither can lie.
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Storage array; it holds no reset because only written words are read.
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : spsc_fifo
`default_nettype wire

//--- spsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_top #(
    parameter int WORD_W = spsc_pkg::SPSC_WORD_W,
    parameter int DEPTH  = spsc_pkg::SPSC_FIFO_DEPTH
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 ARST_N,
    input  wire logic                 RESERVE_SCAN,
    input  wire logic                 DEDICATED_MODE,
    input  wire spsc_pkg::spsc_pins_t PIN_I,
    output spsc_pkg::spsc_pins_t      PIN_O,
    output spsc_pkg::spsc_pins_t      PIN_OE,
    input  wire spsc_pkg::spsc_pins_t USER_O,
    input  wire spsc_pkg::spsc_pins_t USER_OE,
    output spsc_pkg::spsc_pins_t      USER_I,
    input  wire logic [WORD_W-1:0]    LOAD_DATA,
    output logic                      CAPT_VALID,
    input  wire logic                 CAPT_READY,
    output logic [WORD_W-1:0]         CAPT_DATA,
    input  wire logic                 OVERRUN_CLR,
    output logic                      OVERRUN,
    output logic                      SCAN_ACTIVE,
    output spsc_pkg::spsc_tap_t       TAP_STATE,
    output logic [spsc_pkg::SPSC_IR_W-1:0] INSTR
);
    import spsc_pkg::*;

    localparam int BW = $clog2(WORD_W);

    // Standard next-state map of the scan controller.
    function automatic spsc_tap_t tap_next(input spsc_tap_t s, input logic tms);
        unique case (s)
            TAP_RESET:    tap_next = tms ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   tap_next = tms ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   tap_next = tms ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   tap_next = tms ? TAP_SEL_DR   : TAP_IDLE;
        endcase
    endfunction : tap_next

    // Two-stage synchronisers for every pin; the first stage feeds only the second.
    // They reset to the idle levels, so no false claim or edge follows reset.
    spsc_pins_t pin_m_q;
    spsc_pins_t pin_s_q;
    logic       tck_prev_q;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_m_q    <= SPSC_SYNC_RESET;
            pin_s_q    <= SPSC_SYNC_RESET;
            tck_prev_q <= 1'b0;
        end else begin
            pin_m_q    <= PIN_I;
            pin_s_q    <= pin_m_q;
            tck_prev_q <= pin_s_q.tck;
        end
    end

    // Edge detection on the sampled test clock, which is far slower than ours.
    wire tck_rise = pin_s_q.tck && !tck_prev_q;
    wire tck_fall = !pin_s_q.tck && tck_prev_q;
    wire tms_s    = pin_s_q.tms;
    wire tdi_s    = pin_s_q.tdi;

    // Ownership of the pins.
    logic claimed_q;
    logic claimed_d;
    wire  flexible  = RESERVE_SCAN && !DEDICATED_MODE;
    wire  dedicated = RESERVE_SCAN && DEDICATED_MODE;
    wire  scan_use  = dedicated || (flexible && claimed_q);

    // Controller runs only while the pins belong to the scan port.
    spsc_tap_t tap_q;
    spsc_tap_t tap_d;
    wire       tap_step  = scan_use && tck_rise;
    wire       enter_rst = tap_step && (tap_next(tap_q, tms_s) == TAP_RESET);
    assign tap_d = tap_step ? tap_next(tap_q, tms_s) : tap_q;

    // Claim on mode select low, give back on reaching reset; dedicated never shares.
    assign claimed_d = !flexible                  ? 1'b0 :
                       (!claimed_q && !tms_s)     ? 1'b1 :
                       (claimed_q && enter_rst)   ? 1'b0 :
                       claimed_q;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_q     <= TAP_RESET;
            claimed_q <= 1'b0;
        end else begin
            tap_q     <= (scan_use || dedicated) ? tap_d : TAP_RESET;
            claimed_q <= claimed_d;
        end
    end

    // Shift path decoding.
    wire shift_dr = (tap_q == TAP_SHIFT_DR);
    wire shift_ir = (tap_q == TAP_SHIFT_IR);
    wire cap_dr   = (tap_q == TAP_CAP_DR);
    wire cap_ir   = (tap_q == TAP_CAP_IR);
    wire upd_ir   = (tap_q == TAP_UPD_IR);

    // Data and instruction shift registers, shifted on test clock rise.
    // The instruction register loads on the fall inside Update-IR, as the standard asks.
    logic [WORD_W-1:0]    dr_q;
    logic [SPSC_IR_W-1:0] ir_sr_q;
    logic [SPSC_IR_W-1:0] ir_q;
    logic [BW-1:0]        bit_q;
    wire                  dr_bit   = tap_step && shift_dr;
    wire                  word_end = dr_bit && (bit_q == BW'(WORD_W-1));
    wire [WORD_W-1:0]     dr_next  = {tdi_s, dr_q[WORD_W-1:1]};

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dr_q    <= '0;
            ir_sr_q <= '0;
            ir_q    <= SPSC_IR_RESET;
            bit_q   <= '0;
        end else if (tap_step) begin
            if (cap_dr) begin
                dr_q  <= LOAD_DATA;
                bit_q <= '0;
            end else if (shift_dr) begin
                dr_q  <= dr_next;
                bit_q <= (bit_q == BW'(WORD_W-1)) ? '0 : bit_q + 1'b1;
            end
            if (cap_ir) begin
                ir_sr_q <= SPSC_IR_CAPTURE;
            end else if (shift_ir) begin
                ir_sr_q <= {tdi_s, ir_sr_q[SPSC_IR_W-1:1]};
            end
        end else if (tck_fall && upd_ir) begin
            ir_q <= ir_sr_q;
        end else if (tap_q == TAP_RESET) begin
            ir_q <= SPSC_IR_RESET;
        end
    end

    // Output bit and its enable change on the falling edge, the enable also dropping as soon as scan use ends, so the controller
    // sees a settled level at its next rising edge.
    logic tdo_q;
    logic tdo_en_q;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tdo_q    <= 1'b0;
            tdo_en_q <= 1'b0;
        end else if (!scan_use) begin
            tdo_en_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q    <= shift_ir ? ir_sr_q[0] : dr_q[0];
            tdo_en_q <= shift_ir || shift_dr;
        end
    end

    // Completed words wait in a holding register until the buffer takes them.
    logic              pend_q;
    logic [WORD_W-1:0] pend_data_q;
    logic              ovr_q;
    logic              fifo_ready;
    wire               push      = pend_q && fifo_ready;
    wire               ovr_event = word_end && pend_q && !push;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_q      <= 1'b0;
            pend_data_q <= '0;
            ovr_q       <= 1'b0;
        end else begin
            if (word_end && (!pend_q || push)) begin
                pend_q      <= 1'b1;
                pend_data_q <= dr_next;
            end else if (push) begin
                pend_q <= 1'b0;
            end
            // A new overrun in the clearing cycle keeps the flag set.
            ovr_q <= ovr_event || (ovr_q && !OVERRUN_CLR);
        end
    end

    spsc_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk      (CORE_CLK),
        .arst_n   (ARST_N),
        .in_valid (pend_q),
        .in_ready (fifo_ready),
        .in_data  (pend_data_q),
        .out_valid(CAPT_VALID),
        .out_ready(CAPT_READY),
        .out_data (CAPT_DATA)
    );

    // Pin multiplexing; mode select stays an input whenever the port is reserved.
    spsc_pins_t pin_o_d;
    spsc_pins_t pin_oe_d;
    spsc_pins_t pin_o_q;
    spsc_pins_t pin_oe_q;

    assign pin_o_d.tck  = scan_use ? 1'b0 : USER_O.tck;
    assign pin_o_d.tdi  = scan_use ? 1'b0 : USER_O.tdi;
    assign pin_o_d.tdo  = scan_use ? tdo_q : USER_O.tdo;
    assign pin_o_d.tms  = RESERVE_SCAN ? 1'b0 : USER_O.tms;
    assign pin_oe_d.tck = scan_use ? 1'b0 : USER_OE.tck;
    assign pin_oe_d.tdi = scan_use ? 1'b0 : USER_OE.tdi;
    assign pin_oe_d.tdo = scan_use ? tdo_en_q : USER_OE.tdo;
    assign pin_oe_d.tms = RESERVE_SCAN ? 1'b0 : USER_OE.tms;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_o_q  <= '0;
            pin_oe_q <= '0;
        end else begin
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    assign PIN_O       = pin_o_q;
    assign PIN_OE      = pin_oe_q;
    assign USER_I      = pin_s_q;
    assign OVERRUN     = ovr_q;
    assign SCAN_ACTIVE = scan_use;
    assign TAP_STATE   = tap_q;
    assign INSTR       = ir_q;

    // Helper counter of consecutive rising edges with mode select high.
    logic [2:0] hi_cnt_q;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hi_cnt_q <= '0;
        end else if (!scan_use) begin
            hi_cnt_q <= '0;
        end else if (tap_step) begin
            hi_cnt_q <= !tms_s ? '0 : (hi_cnt_q == SPSC_CNT_MAX) ? hi_cnt_q
                                                                 : hi_cnt_q + SPSC_CNT_ONE;
        end
    end

    // Checks run on the core clock and stand down while reset is held.
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    a_shift_capture: assert property (dr_bit && !cap_dr |=> dr_q[WORD_W-1] == $past(tdi_s))
        else $error("Data bit not taken from input on clock rise.");
    a_tdo_edge: assert property ($changed(tdo_q) |-> $past(tck_fall) && $past(scan_use))
        else $error("Test output changed away from a falling edge.");
    a_tdo_driven: assert property (tdo_en_q && scan_use |=> PIN_OE.tdo && PIN_O.tdo == $past(tdo_q))
        else $error("Test output not driven during shift.");
    a_user_pass: assert property (!RESERVE_SCAN |=> PIN_OE == $past(USER_OE) && PIN_O == $past(USER_O))
        else $error("Unreserved pins do not follow user side.");
    a_claim_pins: assert property (flexible && !claimed_q && !tms_s |=> claimed_q ##1 !PIN_OE.tck)
        else $error("Low mode select did not claim pins.");
    a_hold_claim: assert property (claimed_q && flexible && !enter_rst |=> claimed_q)
        else $error("Pins released before reset state.");
    a_release_pins: assert property (claimed_q && enter_rst |=> !claimed_q && tap_q == TAP_RESET)
        else $error("Pins not released at reset state.");
    a_five_reset: assert property (scan_use && hi_cnt_q >= 3'(SPSC_RESET_CYCLES) |-> tap_q == TAP_RESET)
        else $error("Reset state not reached after five high clocks.");
    a_dedicated_use: assert property (dedicated |-> scan_use && !claimed_q)
        else $error("Dedicated mode shows pin sharing.");

    // Pin ownership and instruction update checks.
    a_ir_update: assert property (tck_fall && upd_ir |=> ir_q == $past(ir_sr_q))
        else $error("Instruction not loaded on the fall in Update-IR.");
    a_tms_input: assert property (RESERVE_SCAN |=> !PIN_OE.tms)
        else $error("Mode select driven while the port is reserved.");
    a_scan_pins: assert property (scan_use |=> !PIN_OE.tck && !PIN_OE.tdi)
        else $error("Scan input pins driven during scan use.");
    a_held_reset: assert property (!scan_use |=> tap_q == TAP_RESET)
        else $error("Controller left reset while pins are user I/O.");
    a_user_oe: assert property (flexible && !claimed_q |=> PIN_OE.tdo == $past(USER_OE.tdo))
        else $error("Released output pin not returned to user side.");

    c_claim: cover property (flexible && !claimed_q ##1 claimed_q);
    c_release: cover property (claimed_q ##1 !claimed_q);
    c_word: cover property (word_end);
    c_overrun: cover property (ovr_event);
    c_ir_update: cover property (tck_fall && upd_ir);
endmodule : spsc_top
`default_nettype wire

//--- spsc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module spsc_ctrl_model (
    input  wire logic clk,
    input  wire logic tdo_wire,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      drive_en
);
    // The test clock starts low and mode select rests high.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        drive_en = 1'b0;
    end
    // Park the test clock low and set mode select; low claims the pins.
    task automatic park(input logic m);
        @(negedge clk);
        tck = 1'b0;
        tms = m;
        drive_en = 1'b1;
    endtask : park
    // One 80 ns test clock. Data out is read late in the high half,
    // because the synchronised output trails the fall by several cycles.
    task automatic cycle(input logic m, input logic d, output logic q);
        park(m);
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (3) @(negedge clk);
        q = tdo_wire;
    endtask : cycle
endmodule : spsc_ctrl_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spsc_pkg::*;
    logic       core_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       reserve = 1'b0;
    logic       dedicated = 1'b0;
    logic       capt_ready = 1'b0;
    logic       ovr_clr = 1'b0;
    logic       tgl = 1'b0;
    logic [7:0] load_data = 8'h3C;
    spsc_pins_t user_o = 4'h0;
    spsc_pins_t user_oe = 4'h0;
    spsc_pins_t pin_o, pin_oe, user_i, wire_lvl;
    spsc_tap_t  tap_state;
    logic       capt_valid, overrun, scan_active, c_tck, c_tms, c_tdi, c_en, b;
    logic [7:0] capt_data, q8;
    logic [3:0] instr, q4;
    logic [3:0] ir_pat = 4'h6;
    int         errors = 0;
    int         tests_run = 0;
    int         cycles = 0;

    // Undriven lines wander each cycle; mode select has its pull-up.
    assign wire_lvl = {pin_oe.tck ? pin_o.tck : (c_en ? c_tck : tgl),
                       pin_oe.tdi ? pin_o.tdi : (c_en ? c_tdi : tgl),
                       pin_oe.tdo ? pin_o.tdo : tgl,
                       pin_oe.tms ? pin_o.tms : (c_en ? c_tms : 1'b1)};

    spsc_top dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .RESERVE_SCAN(reserve),
        .DEDICATED_MODE(dedicated), .PIN_I(wire_lvl), .PIN_O(pin_o), .PIN_OE(pin_oe),
        .USER_O(user_o), .USER_OE(user_oe), .USER_I(user_i), .LOAD_DATA(load_data),
        .CAPT_VALID(capt_valid), .CAPT_READY(capt_ready), .CAPT_DATA(capt_data),
        .OVERRUN_CLR(ovr_clr), .OVERRUN(overrun), .SCAN_ACTIVE(scan_active),
        .TAP_STATE(tap_state), .INSTR(instr));
    spsc_ctrl_model ctl (.clk(core_clk), .tdo_wire(wire_lvl.tdo), .tck(c_tck),
        .tms(c_tms), .tdi(c_tdi), .drive_en(c_en));

    always #5 core_clk = ~core_clk;
    // A hang is cut short well beyond the few thousand cycles the run needs.
    always @(posedge core_clk) begin
        tgl <= ~tgl;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Mode straps only change under reset, as they are static levels.
    task automatic do_reset(input logic res, input logic ded);
        @(negedge core_clk);
        arst_n = 1'b0;
        reserve = res;
        dedicated = ded;
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask : do_reset

    task automatic settle();
        repeat (4) @(negedge core_clk);
    endtask : settle

    // One data word from an update state back to Update-DR, 12 test clocks.
    task automatic dr_word(input logic [7:0] d, output logic [7:0] q);
        ctl.cycle(1'b1, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        for (int i = 0; i < 8; i++) begin
            ctl.cycle(i == 7, d[i], q[i]);
        end
        ctl.cycle(1'b1, 1'b0, b);
    endtask : dr_word

    task automatic test_unreserved();
        do_reset(1'b0, 1'b0);
        user_oe = 4'hF;
        user_o = 4'hA;
        repeat (6) @(negedge core_clk);
        chk("pin_oe", 8'h0F, {4'h0, pin_oe});
        chk("pin_o", 8'h0A, {4'h0, pin_o});
        chk("user_i", 8'h0A, {4'h0, user_i});
        chk("scan_active", 8'h00, {7'h0, scan_active});
    endtask : test_unreserved

    // Claim, shift the instruction and a data word through both paths.
    task automatic test_claim_shift();
        do_reset(1'b1, 1'b0);
        user_o = 4'hF;
        ctl.park(1'b1);
        settle();
        chk("pin_oe free", 8'h0E, {4'h0, pin_oe});
        ctl.park(1'b0);
        repeat (6) @(negedge core_clk);
        chk("scan_active", 8'h01, {7'h0, scan_active});
        chk("pin_oe claimed", 8'h00, {4'h0, pin_oe});
        ctl.cycle(1'b0, 1'b0, b);
        ctl.cycle(1'b1, 1'b0, b);
        ctl.cycle(1'b1, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        for (int i = 0; i < 4; i++) begin
            ctl.cycle(i == 3, ir_pat[i], q4[i]);
        end
        ctl.cycle(1'b1, 1'b0, b);
        // A falling edge inside Update-IR loads the instruction.
        ctl.park(1'b1);
        settle();
        chk("ir out", {4'h0, SPSC_IR_CAPTURE}, {4'h0, q4});
        chk("instr", 8'h06, {4'h0, instr});
        dr_word(8'hA5, q8);
        settle();
        chk("dr out", 8'h3C, q8);
        chk("capt_valid", 8'h01, {7'h0, capt_valid});
        chk("capt_data", 8'hA5, capt_data);
        capt_ready = 1'b1;
        @(negedge core_clk);
        capt_ready = 1'b0;
    endtask : test_claim_shift

    // Fill the buffer and the pending stage, lose one word, then drain.
    task automatic test_fill_drain();
        for (int k = 1; k <= 18; k++) begin
            dr_word(k[7:0], q8);
        end
        settle();
        chk("overrun", 8'h01, {7'h0, overrun});
        ovr_clr = 1'b1;
        @(negedge core_clk);
        ovr_clr = 1'b0;
        @(negedge core_clk);
        chk("overrun clr", 8'h00, {7'h0, overrun});
        for (int k = 1; k <= 17; k++) begin
            chk("fifo word", k[7:0], capt_valid ? capt_data : 8'hEE);
            capt_ready = 1'b1;
            @(negedge core_clk);
            capt_ready = 1'b0;
            @(negedge core_clk);
        end
        chk("drained", 8'h00, {7'h0, capt_valid});
    endtask : test_fill_drain

    // From Shift-DR the fifth high mode-select clock reaches reset.
    task automatic test_release();
        ctl.cycle(1'b1, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        ctl.cycle(1'b0, 1'b0, b);
        for (int i = 0; i < 4; i++) begin
            ctl.cycle(1'b1, 1'b0, b);
        end
        settle();
        chk("held", 8'h01, {7'h0, scan_active});
        chk("tap sel_ir", {4'h0, TAP_SEL_IR}, {4'h0, tap_state});
        ctl.cycle(1'b1, 1'b0, b);
        ctl.park(1'b1);
        settle();
        chk("tap reset", {4'h0, TAP_RESET}, {4'h0, tap_state});
        chk("released", 8'h00, {7'h0, scan_active});
        chk("pin_oe user", 8'h0E, {4'h0, pin_oe});
    endtask : test_release

    task automatic test_dedicated();
        do_reset(1'b1, 1'b1);
        ctl.park(1'b1);
        settle();
        chk("ded active", 8'h01, {7'h0, scan_active});
        for (int i = 0; i < 5; i++) begin
            ctl.cycle(1'b1, 1'b0, b);
        end
        ctl.cycle(1'b0, 1'b0, b);
        settle();
        chk("ded idle", {4'h0, TAP_IDLE}, {4'h0, tap_state});
        chk("ded kept", 8'h01, {7'h0, scan_active});
    endtask : test_dedicated

    initial begin
        test_unreserved();
        test_claim_shift();
        test_fill_drain();
        test_release();
        test_dedicated();
        close_out();
    end
endmodule : testbench
`default_nettype wire
